// File: inc/mbag_pkg.sv
package mbag_pkg;
    // register byte addresses on the wishbone bus
    localparam logic [7:0] REG_MODE_OFF = 8'h00;
    localparam logic [7:0] REG_REV_OFF = 8'h04;
    localparam logic [7:0] REG_XSTART_OFF = 8'h08;
    localparam logic [7:0] REG_XEND_OFF = 8'h0C;
    localparam logic [7:0] REG_YSTART_OFF = 8'h10;
    localparam logic [7:0] REG_YEND_OFF = 8'h14;
    localparam logic [7:0] REG_STATUS_OFF = 8'h18;

    // address_mode_control fields
    localparam int X_SEL_LSB = 0;
    localparam int Y_SEL_LSB = 4;
    localparam int REV_SEL_LSB = 8;
    localparam int Y_EN_BIT = 14;
    localparam int X_EN_BIT = 15;
    // bit_reverse_control fields
    localparam int REV_EN_BIT = 15;
    localparam int REV_MOD_MSB = 14;
    // status fields
    localparam int STAT_WRAP_BIT = 0;
    localparam int STAT_REV_BIT = 1;
    localparam int STAT_EA_LSB = 16;

    localparam logic [3:0] SEL_DISABLED = 4'hF;

    // reset values: every pointer select parked on the disabled code
    localparam logic [15:0] MODE_CTRL_RST = 16'h0FFF;
    localparam logic [15:0] REV_CTRL_RST = 16'h0000;
    localparam logic [15:0] BOUND_RST = 16'h0000;
    localparam logic [15:0] ONE_16 = 16'h0001;

    typedef enum logic [1:0] {
        SPACE_XR = 2'b00,
        SPACE_XW = 2'b01,
        SPACE_Y = 2'b10
    } mbag_space_t;

    typedef enum logic [1:0] {
        MODE_IND = 2'b00,
        MODE_POST = 2'b01,
        MODE_PRE = 2'b10,
        MODE_OFFSET = 2'b11
    } mbag_mode_t;
endpackage

// File: src/mbag_bitrev_add.sv
`timescale 1ns/1ps
`default_nettype none
module mbag_bitrev_add (
    // word index and pivot
    input wire logic [14:0] ptrWord,
    input wire logic [14:0] modifier,
    // reversed-carry sum
    output logic [14:0] sumWord
);
    logic [14:0] ptrRev;
    logic [14:0] modRev;
    logic [14:0] sumRev;

    // carries run from msb toward lsb: add in mirrored order
    genvar i;
    generate
        for (i = 0; i < 15; i++) begin : g_mirror
            assign ptrRev[i] = ptrWord[14 - i];
            assign modRev[i] = modifier[14 - i];
            assign sumWord[i] = sumRev[14 - i];
        end
    endgenerate

    assign sumRev = ptrRev + modRev;
endmodule
`default_nettype wire

// File: src/mbag_modulo_wrap.sv
`timescale 1ns/1ps
`default_nettype none
module mbag_modulo_wrap (
    // candidate address and buffer bounds
    input wire logic [15:0] addr,
    input wire logic [15:0] bufStart,
    input wire logic [15:0] bufEnd,
    input wire logic decrement,
    input wire logic wordOnly,
    // corrected address
    output logic [15:0] corrected,
    output logic wrapped
);
    import mbag_pkg::*;

    logic [15:0] bufLen;

    assign bufLen = bufEnd - bufStart + ONE_16;

    always_comb begin
        corrected = addr;
        wrapped = 1'b0;
        if (!decrement && addr > bufEnd) begin
            corrected = addr - bufLen;
            wrapped = 1'b1;
        end else if (decrement && addr < bufStart) begin
            corrected = addr + bufLen;
            wrapped = 1'b1;
        end
        if (wordOnly) begin
            corrected[0] = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: src/mbag_addr_gen.sv
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mbag_addr_gen (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // request from execution datapath
    input wire logic reqValid,
    input wire mbag_pkg::mbag_space_t reqSpace,
    input wire mbag_pkg::mbag_mode_t reqMode,
    input wire logic [3:0] reqPtrSel,
    input wire logic [15:0] reqPtr,
    input wire logic [15:0] reqOffset,
    input wire logic reqByte,
    // effective address result
    output logic eaValid,
    output logic [15:0] eaAddr,
    // pointer write-back
    output logic wbValid,
    output logic [3:0] wbSel,
    output logic [15:0] wbValue
);
    import mbag_pkg::*;

    logic [15:0] modeCtrl_reg;
    logic [15:0] revCtrl_reg;
    logic [15:0] xStart_reg;
    logic [15:0] xEnd_reg;
    logic [15:0] yStart_reg;
    logic [15:0] yEnd_reg;
    logic wrapFlag_reg;
    logic revFlag_reg;
    logic [3:0] xSel;
    logic [3:0] ySel;
    logic [3:0] revSel;
    logic [14:0] revMod;
    logic isX;
    logic modifies;
    logic revActive;
    logic modActive;
    logic [15:0] sumVal;
    logic [15:0] bufStart;
    logic [15:0] bufEnd;
    logic [15:0] bufLen;
    logic [15:0] corrected;
    logic wrapped;
    logic [14:0] revWord;
    logic [15:0] newPtr;
    logic [15:0] eaNext;
    logic busReq;

    function automatic logic selLive(input logic [3:0] sel, input logic en);
        return (sel != SEL_DISABLED) && en;
    endfunction

    function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = data[7:0];
        end
        if (sel[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    assign xSel = modeCtrl_reg[X_SEL_LSB +: 4];
    assign ySel = modeCtrl_reg[Y_SEL_LSB +: 4];
    assign revSel = modeCtrl_reg[REV_SEL_LSB +: 4];
    assign revMod = revCtrl_reg[REV_MOD_MSB:0];

    assign isX = (reqSpace != SPACE_Y);
    assign modifies = (reqMode == MODE_POST) || (reqMode == MODE_PRE);
    assign sumVal = (reqMode == MODE_IND) ? reqPtr : reqPtr + reqOffset;

    assign revActive = reqValid && (reqSpace == SPACE_XW)
        && selLive(revSel, revCtrl_reg[REV_EN_BIT])
        && (reqPtrSel == revSel) && modifies
        && !reqOffset[15] && (reqOffset != 16'h0000) && !reqByte;

    // reversal shuts X write wrap off
    always_comb begin
        modActive = 1'b0;
        if (reqValid && reqMode != MODE_IND && !revActive) begin
            if (isX) begin
                modActive = selLive(xSel, modeCtrl_reg[X_EN_BIT])
                    && (reqPtrSel == xSel);
            end else begin
                modActive = selLive(ySel, modeCtrl_reg[Y_EN_BIT])
                    && (reqPtrSel == ySel);
            end
        end
    end

    assign bufStart = isX ? xStart_reg : yStart_reg;
    assign bufEnd = isX ? xEnd_reg : yEnd_reg;
    assign bufLen = bufEnd - bufStart + ONE_16;

    mbag_modulo_wrap u_wrap (
        .addr(sumVal),
        .bufStart(bufStart),
        .bufEnd(bufEnd),
        .decrement(reqOffset[15]),
        .wordOnly(!isX),
        .corrected(corrected),
        .wrapped(wrapped)
    );

    mbag_bitrev_add u_rev (
        .ptrWord(reqPtr[15:1]),
        .modifier(revMod),
        .sumWord(revWord)
    );

    always_comb begin
        if (revActive) begin
            newPtr = {revWord, 1'b0};
        end else if (modActive) begin
            newPtr = corrected;
        end else begin
            newPtr = sumVal;
        end
    end

    always_comb begin
        case (reqMode)
            MODE_IND: eaNext = reqPtr;
            MODE_POST: eaNext = revActive ? {reqPtr[15:1], 1'b0} : reqPtr;
            MODE_PRE: eaNext = newPtr;
            MODE_OFFSET: eaNext = newPtr;
            default: eaNext = reqPtr;
        endcase
    end

    // results leave one cycle after the request
    always_ff @(posedge clk) begin
        if (reset) begin
            eaValid <= 1'b0;
            eaAddr <= 16'h0000;
            wrapFlag_reg <= 1'b0;
            revFlag_reg <= 1'b0;
        end else begin
            eaValid <= reqValid;
            if (reqValid) begin
                eaAddr <= eaNext;
                wrapFlag_reg <= modActive && wrapped;
                revFlag_reg <= revActive;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wbValid <= 1'b0;
            wbSel <= 4'h0;
            wbValue <= 16'h0000;
        end else begin
            wbValid <= reqValid && modifies;
            if (reqValid && modifies) begin
                wbSel <= reqPtrSel;
                wbValue <= newPtr;
            end
        end
    end

    // ack one cycle after the strobe; writes land on the ack edge
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busReq;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            modeCtrl_reg <= MODE_CTRL_RST;
            revCtrl_reg <= REV_CTRL_RST;
            xStart_reg <= BOUND_RST;
            xEnd_reg <= BOUND_RST;
            yStart_reg <= BOUND_RST;
            yEnd_reg <= BOUND_RST;
        end else if (busReq && wb_we_i) begin
            case (wb_adr_i)
                REG_MODE_OFF:
                    modeCtrl_reg <= mergeLanes(modeCtrl_reg, wb_dat_i,
                                               wb_sel_i);
                REG_REV_OFF:
                    revCtrl_reg <= mergeLanes(revCtrl_reg, wb_dat_i, wb_sel_i);
                REG_XSTART_OFF:
                    xStart_reg <= mergeLanes(xStart_reg, wb_dat_i, wb_sel_i);
                REG_XEND_OFF:
                    xEnd_reg <= mergeLanes(xEnd_reg, wb_dat_i, wb_sel_i);
                REG_YSTART_OFF:
                    yStart_reg <= mergeLanes(yStart_reg, wb_dat_i, wb_sel_i);
                REG_YEND_OFF:
                    yEnd_reg <= mergeLanes(yEnd_reg, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // unmapped addresses read zero and still ack
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_dat_o <= 32'h00000000;
        end else if (busReq) begin
            case (wb_adr_i)
                REG_MODE_OFF: wb_dat_o <= {16'h0000, modeCtrl_reg};
                REG_REV_OFF: wb_dat_o <= {16'h0000, revCtrl_reg};
                REG_XSTART_OFF: wb_dat_o <= {16'h0000, xStart_reg};
                REG_XEND_OFF: wb_dat_o <= {16'h0000, xEnd_reg};
                REG_YSTART_OFF: wb_dat_o <= {16'h0000, yStart_reg};
                REG_YEND_OFF: wb_dat_o <= {16'h0000, yEnd_reg};
                REG_STATUS_OFF: begin
                    wb_dat_o <= 32'h00000000;
                    wb_dat_o[STAT_EA_LSB +: 16] <= eaAddr;
                    wb_dat_o[STAT_WRAP_BIT] <= wrapFlag_reg;
                    wb_dat_o[STAT_REV_BIT] <= revFlag_reg;
                end
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    x_sel_off_a: assert property (
        reqValid && isX && xSel == SEL_DISABLED |=> !wrapFlag_reg)
        else $error("X wrap with select disabled");
    x_enable_a: assert property (
        reqValid && isX && !modeCtrl_reg[X_EN_BIT] |=> !wrapFlag_reg)
        else $error("X wrap with enable clear");
    y_gate_a: assert property (
        reqValid && !isX && (ySel == SEL_DISABLED
        || !modeCtrl_reg[Y_EN_BIT]) |=> !wrapFlag_reg)
        else $error("Y wrap while disabled");
    past_end_a: assert property (
        modActive && !reqOffset[15] && sumVal > bufEnd
        && reqMode == MODE_PRE |=> wrapFlag_reg
        && eaAddr == $past(sumVal) - $past(bufLen))
        else $error("overshoot not wrapped by length");
    below_start_a: assert property (
        modActive && reqOffset[15] && sumVal < bufStart
        && isX && reqMode == MODE_OFFSET
        |=> eaAddr == $past(sumVal) + $past(bufLen))
        else $error("undershoot not wrapped by length");
    offset_no_wb_a: assert property (
        reqValid && reqMode == MODE_OFFSET |=> !wbValid)
        else $error("offset mode wrote pointer back");
    read_no_rev_a: assert property (
        reqValid && reqSpace != SPACE_XW |=> !revFlag_reg)
        else $error("reversal outside X write");
    rev_gate_a: assert property (
        reqValid && !revCtrl_reg[REV_EN_BIT] |=> !revFlag_reg)
        else $error("reversal with enable clear");
    // the flag outlives the pulse, so look only when a result leaves
    rev_word_a: assert property (
        eaValid && revFlag_reg |-> !eaAddr[0] && !wbValue[0] && wbValid)
        else $error("reversed address not word aligned");
    byte_normal_a: assert property (
        reqValid && reqByte |=> !revFlag_reg)
        else $error("byte access reversed");
    rev_prio_a: assert property (
        revFlag_reg |-> !wrapFlag_reg)
        else $error("wrap applied during reversal");
    y_word_a: assert property (
        modActive && !isX && modifies |=> !wbValue[0])
        else $error("Y circular lsb set");

    wrap_seen_c: cover property (modActive && wrapped);
    rev_seen_c: cover property (revActive && reqMode == MODE_POST);
    wrap_hold_c: cover property (modActive && reqMode == MODE_OFFSET
        && wrapped);
endmodule
`default_nettype wire

// File: test/mbag_reg_file.sv
`timescale 1ns/1ps
`default_nettype none
module mbag_reg_file (
    // clock
    input wire logic clk,
    // preload from the bench
    input wire logic loadEn,
    input wire logic [15:0] loadVal,
    // pointer read and write-back
    input wire logic [3:0] rdSel,
    output logic [15:0] rdVal,
    input wire logic wbValid,
    input wire logic [3:0] wbSel,
    input wire logic [15:0] wbValue
);
    logic [15:0] regs [16];
    // forwarding lets back-to-back modify chains see the newest pointer
    assign rdVal = loadEn ? loadVal :
        (wbValid && wbSel == rdSel) ? wbValue : regs[rdSel];
    always_ff @(posedge clk) begin
        if (wbValid)
            regs[wbSel] <= wbValue;
        if (loadEn)
            regs[rdSel] <= loadVal;
    end
endmodule
`default_nettype wire

// File: test/test_modulo_bitrev_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", nm, e, g); nMismatch++; end end
module test_modulo_bitrev_addr_gen;
    import mbag_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] busAdr = 8'h00;
    logic [31:0] busDatI = 32'h0;
    logic [3:0] busSel = 4'h0;
    logic busWe = 1'b0;
    logic busStb = 1'b0;
    logic busCyc = 1'b0;
    logic [31:0] busDatO;
    logic busAck;
    logic reqValid = 1'b0;
    mbag_space_t reqSpace = SPACE_XR;
    mbag_mode_t reqMode = MODE_IND;
    logic [3:0] reqPtrSel = 4'h0;
    logic [15:0] reqPtr;
    logic [15:0] reqOffset = 16'h0;
    logic reqByte = 1'b0;
    logic loadEn = 1'b0;
    logic [15:0] loadVal = 16'h0;
    logic eaValid, wbValid;
    logic [15:0] eaAddr, wbValue, p, o;
    logic [3:0] wbSel;
    logic [31:0] rdq[$];
    logic [36:0] eaq[$];
    logic [31:0] re;
    logic [36:0] ee;
    int nMismatch = 0;
    int testsRun = 0;
    int n;

    always #5 clk = ~clk;

    mbag_addr_gen i_mbag_addr_gen (.clk(clk), .reset(reset),
        .wb_adr_i(busAdr), .wb_dat_i(busDatI), .wb_sel_i(busSel),
        .wb_we_i(busWe), .wb_stb_i(busStb), .wb_cyc_i(busCyc),
        .wb_dat_o(busDatO), .wb_ack_o(busAck), .reqValid(reqValid),
        .reqSpace(reqSpace), .reqMode(reqMode), .reqPtrSel(reqPtrSel),
        .reqPtr(reqPtr), .reqOffset(reqOffset), .reqByte(reqByte),
        .eaValid(eaValid), .eaAddr(eaAddr), .wbValid(wbValid),
        .wbSel(wbSel), .wbValue(wbValue));
    mbag_reg_file i_mbag_reg_file (.clk(clk), .loadEn(loadEn),
        .loadVal(loadVal), .rdSel(reqPtrSel), .rdVal(reqPtr),
        .wbValid(wbValid), .wbSel(wbSel), .wbValue(wbValue));

    task automatic test_done();
        if (nMismatch == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int k;
        busAdr <= a;
        busWe <= w;
        busDatI <= d;
        busSel <= 4'h3;
        busCyc <= 1'b1;
        busStb <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (busAck !== 1'b1 && k < 20);
        if (busAck !== 1'b1) begin
            nMismatch++;
            test_done();
        end
        busCyc <= 1'b0;
        busStb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rdq.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask

    task automatic idle();
        reqValid <= 1'b0;
        loadEn <= 1'b0;
        @(posedge clk);
    endtask

    // one request per cycle; consecutive calls run back to back
    task automatic rq(input mbag_space_t s, input mbag_mode_t m,
        input logic [3:0] r, input logic [15:0] ptr, input logic [15:0] off,
        input logic b, input logic [15:0] ea, input logic wv,
        input logic [15:0] wb);
        reqValid <= 1'b1;
        reqSpace <= s;
        reqMode <= m;
        reqPtrSel <= r;
        loadEn <= 1'b1;
        loadVal <= ptr;
        reqOffset <= off;
        reqByte <= b;
        eaq.push_back({r, wv, wb, ea});
        p = ptr;
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (busAck === 1'b1 && busWe === 1'b0) begin
            re = rdq.pop_front();
            `CHK("readData", re, busDatO)
        end
        if (eaValid === 1'b1) begin
            ee = eaq.pop_front();
            `CHK("eaAddr", ee[15:0], eaAddr)
            `CHK("wbValid", ee[32], wbValid)
            if (ee[32]) begin
                `CHK("wbValue", ee[31:16], wbValue)
                `CHK("wbSel", ee[36:33], wbSel)
            end
        end
    end

    initial begin
        void'($urandom(32'hA9DDF6D7));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'h00, 32'h00000FFF);
        rd(8'h1C, 32'h0);
        bus(8'h08, 1'b1, 32'h1000);
        bus(8'h0C, 1'b1, 32'h100F);
        bus(8'h10, 1'b1, 32'h2000);
        bus(8'h14, 1'b1, 32'h201F);
        rd(8'h0C, 32'h100F);
        bus(8'h00, 1'b1, 32'h8FF2);
        rq(SPACE_XR, MODE_POST, 2, 16'h100E, 4, 0, 16'h100E, 1, 16'h1002);
        rq(SPACE_XR, MODE_OFFSET, 2, 16'h100C, 6, 0, 16'h1002, 0, 0);
        rq(SPACE_XR, MODE_PRE, 2, 16'h1002, 16'hFFFC, 0, 16'h100E, 1,
           16'h100E);
        rq(SPACE_XR, MODE_PRE, 3, 16'h100E, 4, 0, 16'h1012, 1, 16'h1012);
        // offset below the start bound wraps up, pointer untouched
        rq(SPACE_XR, MODE_OFFSET, 2, 16'h1002, 16'hFFFA, 0, 16'h100C, 0,
           0);
        idle();
        // status: last address and the wrap flag
        rd(8'h18, 32'h100C0001);
        bus(8'h00, 1'b1, 32'h0FF2);
        rq(SPACE_XR, MODE_PRE, 2, 16'h100E, 4, 0, 16'h1012, 1, 16'h1012);
        idle();
        bus(8'h00, 1'b1, 32'hCFFF);
        rq(SPACE_XW, MODE_PRE, 15, 16'h100E, 4, 0, 16'h1012, 1, 16'h1012);
        idle();
        bus(8'h00, 1'b1, 32'h4F5F);
        rq(SPACE_Y, MODE_PRE, 5, 16'h201E, 2, 0, 16'h2000, 1, 16'h2000);
        rq(SPACE_Y, MODE_PRE, 5, 16'h201D, 2, 0, 16'h201E, 1, 16'h201E);
        idle();
        bus(8'h00, 1'b1, 32'h82F2);
        // pivot of half a 16-word buffer
        bus(8'h04, 1'b1, 32'h8008);
        // a gap before using the reversed pointer after the pivot write
        rd(8'h04, 32'h8008);
        // buffer at 0x1000 has its low address bits clear
        rq(SPACE_XW, MODE_POST, 2, 16'h1000, 2, 0, 16'h1000, 1, 16'h1010);
        rq(SPACE_XW, MODE_PRE, 2, 16'h1010, 2, 0, 16'h1008, 1, 16'h1008);
        rq(SPACE_XW, MODE_POST, 2, 16'h1001, 2, 0, 16'h1000, 1, 16'h1010);
        rq(SPACE_XR, MODE_PRE, 2, 16'h100E, 4, 0, 16'h1002, 1, 16'h1002);
        rq(SPACE_XW, MODE_PRE, 2, 16'h1000, 1, 1, 16'h1001, 1, 16'h1001);
        rq(SPACE_XW, MODE_OFFSET, 2, 16'h1000, 2, 0, 16'h1002, 0, 0);
        rq(SPACE_XW, MODE_IND, 2, 16'h1006, 2, 0, 16'h1006, 0, 0);
        rq(SPACE_Y, MODE_PRE, 2, 16'h1000, 2, 0, 16'h1002, 1, 16'h1002);
        rq(SPACE_XW, MODE_PRE, 2, 16'h1008, 2, 0, 16'h1018, 1,
           16'h1018);
        idle();
        // status: last address and the reversal flag
        rd(8'h18, 32'h10180002);
        bus(8'h00, 1'b1, 32'h0FFF);
        o = 16'($urandom);
        rq(SPACE_XR, MODE_PRE, 4, o, 0, 0, o, 1, o);
        repeat (24) begin
            o = 16'($urandom_range(0, 15)) - 16'h0008;
            p = p + o;
            loadEn <= 1'b0;
            reqOffset <= o;
            eaq.push_back({4'h4, 1'b1, p, p});
            @(posedge clk);
        end
        idle();
        n = 0;
        while ((eaq.size() != 0 || rdq.size() != 0) && n < 10) begin
            @(posedge clk);
            n++;
        end
        if (eaq.size() != 0 || rdq.size() != 0)
            nMismatch++;
        test_done();
    end
endmodule
`default_nettype wire
